/* dsc_pkg.sv */
/*
  constants for the dual slope converter phase sequencer.
  assumes a 25 MHz system clock and a two-pin phase select on the analog part.
*/
package dsc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int COUNT_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // phase codes, first select pin is the msb
  localparam logic [1:0] PH_INTEGRATOR_ZERO_PHASE = 2'h0;
  localparam logic [1:0] PH_AZ = 2'h1;
  localparam logic [1:0] PH_INT = 2'h2;
  localparam logic [1:0] PH_DEINTEGRATE_PHASE = 2'h3;
  // register offsets (word index on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_INT_COUNT = 4'h1;
  localparam logic [3:0] REG_AZ_COUNT = 4'h2;
  localparam logic [3:0] REG_DEINTEGRATE_PHASE_MAX = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h5;
  localparam logic [3:0] REG_INTEGRATOR_ZERO_PHASE_COUNT = 4'h6;
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_SIGN_BIT = 2;
  localparam int ST_OVR_BIT = 3;
  localparam int ST_PHASE_LSB = 4;
  localparam int ST_INTEGRATOR_ZERO_PHASE_TO_BIT = 6;
  // reset values of the timing registers
  localparam logic [COUNT_W-1:0] INT_COUNT_RST = 24'h002710;
  localparam logic [COUNT_W-1:0] AZ_COUNT_RST = 24'h002710;
  localparam logic [COUNT_W-1:0] DEINTEGRATE_PHASE_MAX_RST = 24'h007530;
  // typical integrator zero length, in microseconds, and its cycle count
  localparam int INTEGRATOR_ZERO_PHASE_TYP_US = 1000;
  localparam int INTEGRATOR_ZERO_PHASE_TYP_CYC = INTEGRATOR_ZERO_PHASE_TYP_US * (CLK_HZ / 1000000);
  // integrator zero is abandoned after this many typical lengths
  localparam int INTEGRATOR_ZERO_PHASE_LIMIT_MULT = 8;
  localparam logic [COUNT_W-1:0] ONE_CNT = 24'h000001;
  localparam logic [COUNT_W-1:0] ZERO_CNT = 24'h000000;
endpackage

/* dsc_sync.sv */
/*
  three-stage synchroniser with agreement filter and falling/rising detect.
  assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module dsc_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic async_i,
  output logic level_o,
  output logic fall_o,
  output logic rise_o
);
  logic s1;
  logic s2;
  logic s3;

  // three flops; the filtered level follows once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end else if (ce_i) begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
      if (s2 == s3) begin
        level_o <= s3;
        fall_o <= level_o & ~s3;
        rise_o <= ~level_o & s3;
      end
    end
  end
endmodule // dsc_sync

/* dsc_timer.sv */
/*
  clearable up-counter with terminal compare, used for phase timing.
  assumes one clock enable shared with the sequencer.
*/
`timescale 1ns/1ps
module dsc_timer
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [COUNT_W-1:0] limit_i,
  output logic [COUNT_W-1:0] count_o,
  output logic hit_o
);
  // counts while run is high; hit marks the count reaching one below the limit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_o <= ZERO_CNT;
    end else if (ce_i) begin
      if (clear_i) begin
        count_o <= ZERO_CNT;
      end else if (run_i) begin
        count_o <= count_o + ONE_CNT;
      end
    end
  end

  assign hit_o = run_i && (count_o + ONE_CNT >= limit_i);
endmodule // dsc_timer

/* dsc_sequencer.sv */
/*
  conversion sequencer that drives the two phase select pins of a dual slope
  integrating front end, times each phase and captures sign and count.
  assumes the comparator output arrives asynchronously and the analog part
  decodes the select pins itself.
*/
// Summary of operation
// R1 - analog part decodes 00 zero, 01 auto zero, 10 integrate, 11 deintegrate
// R2 - auto zero grounds inputs, closes auto zero, sample, ground switches
// R3 - integration closes only the input connect switches
// R4 - deintegration closes ground and one reference switch picked by sign
// R5 - integrator zero closes sample, ground and system offset switches
// R6 - comparator high means positive input during integration, giving sign
// R7 - comparator level is ignored during auto zero
// R8 - comparator falls when integrator crosses zero in deintegration
// R9 - phases run auto zero, integrate, deintegrate, integrator zero
// R10 - integration lasts a fixed programmed number of clocks
// R11 - comparator sampled as sign just before integration ends
// R12 - integration ends by switching select 10 straight to 11
// R13 - deintegration clocks counted from select 11 to comparator fall
// R14 - on comparator fall the count is stopped and stored as result
// R15 - after deintegration select 00 until comparator returns high
// R16 - then select 01 and hold until next conversion
// R17 - continuous mode keeps auto zero a programmed settling length
// R18 - integrator zero expected near one millisecond; long overrun is flagged
// R19 - result is raw count so software can correct comparator delay
// R20 - comparator forced high at deintegration start, so fall is meaningful
// R21 - first select pin is msb, second is lsb of phase code
// R22 - comparator passes a multi-flop synchroniser before use
`timescale 1ns/1ps
module dsc_sequencer
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic phase_a_o,
  output logic phase_b_o,
  input wire logic comparator_out_i
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_AZ = 3'b001,
    ST_INT = 3'b010,
    ST_DEINTEGRATE_PHASE = 3'b011,
    ST_INTEGRATOR_ZERO_PHASE = 3'b100
  } state_t;

  state_t state;
  state_t next_state;
  logic [COUNT_W-1:0] int_count;
  logic [COUNT_W-1:0] az_count;
  logic [COUNT_W-1:0] deintegrate_phase_max;
  logic [COUNT_W-1:0] result;
  logic continuous;
  logic start_req;
  logic done;
  logic sign;
  logic overrange;
  logic integrator_zero_phase_timeout;
  logic cmp_level;
  logic cmp_fall;
  logic [COUNT_W-1:0] count;
  logic timer_hit;
  logic timer_clear;
  logic timer_run;
  logic [COUNT_W-1:0] timer_limit;
  logic [1:0] next_phase;
  logic done_set;
  logic done_clr;
  logic [COUNT_W-1:0] integrator_zero_phase_count;

  // phase code of each sequencer state
  function automatic logic [1:0] phase_of(input state_t s);
    case (s)
      ST_INT: phase_of = PH_INT;
      ST_DEINTEGRATE_PHASE: phase_of = PH_DEINTEGRATE_PHASE;
      ST_INTEGRATOR_ZERO_PHASE: phase_of = PH_INTEGRATOR_ZERO_PHASE;
      default: phase_of = PH_AZ;
    endcase
  endfunction

  // comparator crosses into the clock domain here
  // its rising edge is left open: integrator zero waits on the level instead
  dsc_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(comparator_out_i),
    .level_o(cmp_level),
    .fall_o(cmp_fall),
    .rise_o()
  ); // [R22]

  // one counter times every phase; same clock for integrate and deintegrate
  // hit is combinational, so auto zero and integration end on exactly their programmed count
  dsc_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(timer_clear),
    .run_i(timer_run),
    .limit_i(timer_limit),
    .count_o(count),
    .hit_o(timer_hit)
  ); // [R13]

  // limit for the current phase
  always_comb begin
    case (state)
      ST_AZ: timer_limit = az_count;
      ST_INT: timer_limit = int_count; // [R10]
      ST_DEINTEGRATE_PHASE: timer_limit = deintegrate_phase_max;
      ST_INTEGRATOR_ZERO_PHASE: timer_limit = COUNT_W'(INTEGRATOR_ZERO_PHASE_TYP_CYC * INTEGRATOR_ZERO_PHASE_LIMIT_MULT); // [R18]
      // idle never runs the timer, so its limit is never compared
      default: timer_limit = ZERO_CNT;
    endcase
  end

  // phase transitions in the fixed order
  always_comb begin
    next_state = state;
    timer_clear = 1'b0;
    timer_run = (state != ST_IDLE);
    case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = ST_AZ;
          timer_clear = 1'b1;
        end
      end
      ST_AZ: begin
        // comparator is not looked at here
        if (timer_hit) begin // [R7] [R17]
          next_state = ST_INT; // [R9]
          timer_clear = 1'b1;
        end
      end
      ST_INT: begin
        if (timer_hit) begin
          next_state = ST_DEINTEGRATE_PHASE; // [R12]
          timer_clear = 1'b1;
        end
      end
      ST_DEINTEGRATE_PHASE: begin
        if (cmp_fall || timer_hit) begin // [R8] [R14]
          next_state = ST_INTEGRATOR_ZERO_PHASE; // [R15]
          timer_clear = 1'b1;
        end
      end
      ST_INTEGRATOR_ZERO_PHASE: begin
        // a start written mid-conversion is taken here without passing idle
        if (cmp_level || timer_hit) begin
          next_state = (continuous || start_req) ? ST_AZ : ST_IDLE; // [R16]
          timer_clear = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        timer_clear = 1'b1;
      end
    endcase
  end

  // state register
  // unused state codes fall back to idle through the default branch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign next_phase = phase_of(next_state);

  // select pins driven from flops, a is the msb
  // reset leaves the part in auto zero, its resting phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_a_o <= PH_AZ[1];
      phase_b_o <= PH_AZ[0];
    end else if (ce_i) begin
      phase_a_o <= next_phase[1]; // [R21] [R1]
      phase_b_o <= next_phase[0];
    end
  end

  // sign latched on the last integration cycle
  // the filtered level lags the pin by about four clocks; integration outlasts it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sign <= 1'b0;
    end else if (ce_i && state == ST_INT && timer_hit) begin
      sign <= cmp_level; // [R11] [R6] [R4]
    end
  end

  // deintegration count captured on comparator fall; early fall ignored is
  // avoided since the part drives the comparator high at phase start
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result <= ZERO_CNT;
      overrange <= 1'b0;
    end else if (ce_i && state == ST_DEINTEGRATE_PHASE) begin
      if (cmp_fall) begin // [R20]
        result <= count + ONE_CNT; // [R14] [R19]
        overrange <= 1'b0;
      end else if (timer_hit) begin
        result <= deintegrate_phase_max;
        overrange <= 1'b1;
      end
    end
  end

  // integrator zero overrun flag
  // a comparator that never returns high must not hang the sequence
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      integrator_zero_phase_timeout <= 1'b0;
      integrator_zero_phase_count <= ZERO_CNT;
    end else if (ce_i && state == ST_INTEGRATOR_ZERO_PHASE && (cmp_level || timer_hit)) begin
      integrator_zero_phase_timeout <= ~cmp_level; // [R18]
      integrator_zero_phase_count <= count + ONE_CNT;
    end
  end

  // done is sticky; a new completion wins over a software clear
  assign done_set = ce_i && state == ST_DEINTEGRATE_PHASE && next_state == ST_INTEGRATOR_ZERO_PHASE;
  assign done_clr = ce_i && wr_i && addr_i == REG_STATUS && wdata_i[ST_DONE_BIT];
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done <= 1'b0;
    end else if (done_set) begin
      done <= 1'b1;
    end else if (done_clr) begin
      done <= 1'b0;
    end
  end

  // register writes; start is held until the sequencer takes it
  // the register port freezes with the rest of the block while ce_i is low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_count <= INT_COUNT_RST;
      az_count <= AZ_COUNT_RST;
      deintegrate_phase_max <= DEINTEGRATE_PHASE_MAX_RST;
      continuous <= 1'b0;
      start_req <= 1'b0;
    end else if (ce_i) begin
      // a pending start is consumed only on entry to auto zero, so a start
      // written during a conversion waits for integrator zero to finish
      if (start_req && state != ST_AZ && next_state == ST_AZ) begin
        start_req <= 1'b0;
      end
      if (wr_i) begin
        case (addr_i)
          REG_CTRL: begin
            continuous <= wdata_i[CTRL_CONT_BIT];
            if (wdata_i[CTRL_START_BIT]) begin
              start_req <= 1'b1;
            end
          end
          REG_INT_COUNT: int_count <= wdata_i[COUNT_W-1:0];
          REG_AZ_COUNT: az_count <= wdata_i[COUNT_W-1:0];
          REG_DEINTEGRATE_PHASE_MAX: deintegrate_phase_max <= wdata_i[COUNT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  // status mirrors the select pins, so software sees the phase the part sees
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i && rd_i) begin
      rdata_o <= '0;
      case (addr_i)
        REG_CTRL: rdata_o[CTRL_CONT_BIT] <= continuous;
        REG_INT_COUNT: rdata_o[COUNT_W-1:0] <= int_count;
        REG_AZ_COUNT: rdata_o[COUNT_W-1:0] <= az_count;
        REG_DEINTEGRATE_PHASE_MAX: rdata_o[COUNT_W-1:0] <= deintegrate_phase_max;
        REG_STATUS: begin
          rdata_o[ST_BUSY_BIT] <= (state != ST_IDLE);
          rdata_o[ST_DONE_BIT] <= done;
          rdata_o[ST_SIGN_BIT] <= sign;
          rdata_o[ST_OVR_BIT] <= overrange;
          rdata_o[ST_PHASE_LSB +: 2] <= {phase_a_o, phase_b_o};
          rdata_o[ST_INTEGRATOR_ZERO_PHASE_TO_BIT] <= integrator_zero_phase_timeout;
        end
        REG_RESULT: rdata_o[COUNT_W-1:0] <= result;
        REG_INTEGRATOR_ZERO_PHASE_COUNT: rdata_o[COUNT_W-1:0] <= integrator_zero_phase_count;
        default: rdata_o <= '0;
      endcase
    end
  end
endmodule // dsc_sequencer

/* dsc_dev_model.sv */
/*
  behavioural analog front end: decodes the phase pins, models the comparator.
  assumes the pins change just after rising edges of clk_i.
*/
`timescale 1ns/1ps
module dsc_dev_model
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic sign_i,
  input wire logic [15:0] deint_len_i,
  input wire logic [15:0] zero_len_i,
  output logic comparator_out_o
);
  logic [1:0] last = 2'h1;
  logic [15:0] age = 16'h0;
  logic pol = 1'b0;
  logic c = 1'b0;
  logic [6:0] sw;
  wire logic [1:0] ph = {phase_a_i, phase_b_i};
  wire logic [15:0] next_age = (ph != last) ? 16'h0 : age + 16'h1;
  assign comparator_out_o = c;
  // switches: input, ref+, ref-, auto zero, ref sample, ground, offset
  always_comb begin
    case (ph)
      PH_AZ: sw = 7'h0e;
      PH_INT: sw = 7'h40;
      PH_DEINTEGRATE_PHASE: sw = {1'b0, pol, ~pol, 4'h2};
      default: sw = 7'h07;
    endcase
  end
  // phase age, polarity latch and comparator level
  always @(posedge clk_i) begin
    last <= ph;
    age <= next_age;
    if (ph == PH_INT) pol <= sign_i;
    case (ph)
      PH_AZ: c <= ~c;
      PH_INT: c <= sign_i;
      PH_DEINTEGRATE_PHASE: c <= (next_age < deint_len_i);
      default: c <= (next_age >= zero_len_i);
    endcase
  end
endmodule // dsc_dev_model

/* dsc_chk.sv */
/*
  phase sequencing checker bound to the ports of dsc_sequencer.
  assumes ce_i is held high while phase timing is judged.
*/
`timescale 1ns/1ps
module dsc_chk
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic phase_a_o,
  input wire logic phase_b_o,
  input wire logic comparator_out_i
);
  logic [COUNT_W-1:0] int_cnt, dmax, n_int, n_deint;
  wire logic [1:0] ph = {phase_a_o, phase_b_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // programmed counts seen on the register port
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_cnt <= INT_COUNT_RST;
      dmax <= DEINTEGRATE_PHASE_MAX_RST;
    end else if (wr_i && addr_i == REG_INT_COUNT) begin
      int_cnt <= wdata_i[COUNT_W-1:0];
    end else if (wr_i && addr_i == REG_DEINTEGRATE_PHASE_MAX) begin
      dmax <= wdata_i[COUNT_W-1:0];
    end
  end
  // cycles spent so far in integration and deintegration
  always_ff @(posedge clk_i) begin
    n_int <= (ph == PH_INT) ? n_int + ONE_CNT : ZERO_CNT;
    n_deint <= (ph == PH_DEINTEGRATE_PHASE) ? n_deint + ONE_CNT : ZERO_CNT;
  end
  sequence leave_s(logic [1:0] p);
    ph == p ##1 ph != p;
  endsequence
  a_reset_autozero: assert property ($rose(rst_n_i) |-> ph == PH_AZ)
    else $error("pins not auto zero after reset");
  a_int_to_deint: assert property (leave_s(PH_INT) |-> ph == PH_DEINTEGRATE_PHASE)
    else $error("integration not followed by deintegration");
  a_deint_to_zero: assert property (leave_s(PH_DEINTEGRATE_PHASE) |-> ph == PH_INTEGRATOR_ZERO_PHASE)
    else $error("deintegration not followed by integrator zero");
  a_zero_to_autozero: assert property (leave_s(PH_INTEGRATOR_ZERO_PHASE) |-> ph == PH_AZ)
    else $error("integrator zero not followed by auto zero");
  a_autozero_to_int: assert property (leave_s(PH_AZ) |-> ph == PH_INT)
    else $error("auto zero not followed by integration");
  a_int_length: assert property (leave_s(PH_INT) |-> n_int == int_cnt)
    else $error("integration length differs from programmed count");
  a_deint_bound: assert property (ph == PH_DEINTEGRATE_PHASE |-> n_deint < dmax)
    else $error("deintegration ran past its maximum");
  a_fall_stops: assert property (ph == PH_DEINTEGRATE_PHASE && $fell(comparator_out_i)
    |-> ##[1:8] ph == PH_INTEGRATOR_ZERO_PHASE)
    else $error("comparator fall did not end deintegration");
  a_zero_exit: assert property (ph == PH_INTEGRATOR_ZERO_PHASE && $rose(comparator_out_i)
    |-> ##[1:8] ph == PH_AZ)
    else $error("comparator rise did not end integrator zero");
  a_zero_hold: assert property ((ph == PH_INTEGRATOR_ZERO_PHASE && !comparator_out_i) [*6]
    |=> ph == PH_INTEGRATOR_ZERO_PHASE)
    else $error("integrator zero left while comparator low");
  a_unmapped_zero: assert property (rd_i && addr_i > REG_INTEGRATOR_ZERO_PHASE_COUNT |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data changed without a read");
endmodule // dsc_chk
bind dsc_sequencer dsc_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .phase_a_o(phase_a_o), .phase_b_o(phase_b_o), .comparator_out_i(comparator_out_i));

/* tb_top.sv */
/*
  self-checking bench for dsc_sequencer driving a behavioural front end.
  assumes the checker is bound to the sequencer by its own file.
*/
`timescale 1ns/1ps
module tb_top;
  import dsc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = 4'h0;
  logic [DATA_W-1:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o, d;
  logic phase_a_o, phase_b_o, comp;
  logic sign = 1'b1;
  logic [15:0] dlen = 16'h1e;
  logic [15:0] zlen = 16'hf;
  int n_fail = 0;
  int n_checks = 0;
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  dsc_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .phase_a_o(phase_a_o), .phase_b_o(phase_b_o), .comparator_out_i(comp));
  dsc_dev_model dev (.clk_i(clk_i), .phase_a_i(phase_a_o), .phase_b_i(phase_b_o),
    .sign_i(sign), .deint_len_i(dlen), .zero_len_i(zlen), .comparator_out_o(comp));
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [DATA_W-1:0] lo, hi, g);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // poll status until a conversion reports done
  task automatic wait_done();
    for (int i = 0; i < 3000; i++) begin
      rd(REG_STATUS);
      if (d[ST_DONE_BIT] === 1'b1) break;
    end
    chk("done", 32'h2, d & 32'h2);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
  // main test sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(REG_INT_COUNT);
    chk("int_count", 32'h2710, d);
    rd(REG_AZ_COUNT);
    chk("settle_count", 32'h2710, d);
    rd(REG_DEINTEGRATE_PHASE_MAX);
    chk("deint_max", 32'h7530, d);
    rd(REG_STATUS);
    chk("status", 32'h10, d);
    wr(4'h7, 32'h5);
    rd(4'h7);
    chk("unmapped", 32'h0, d);
    $display("test reset values finished");
    wr(REG_INT_COUNT, 32'd20);
    wr(REG_AZ_COUNT, 32'd10);
    wr(REG_DEINTEGRATE_PHASE_MAX, 32'd200);
    wr(REG_CTRL, 32'h1);
    wait_done();
    rd(REG_STATUS);
    chk("sign_ovr", 32'h4, d & 32'hc);
    rd(REG_RESULT);
    chk_rng("result", 32'd30, 32'd42, d);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS);
    chk("done_clear", 32'h0, d & 32'h2);
    repeat (40) @(posedge clk_i);
    rd(REG_INTEGRATOR_ZERO_PHASE_COUNT);
    chk_rng("zero_count", 32'd14, 32'd26, d);
    $display("test positive conversion finished");
    sign <= 1'b0;
    dlen <= 16'd1000;
    wr(REG_DEINTEGRATE_PHASE_MAX, 32'd50);
    wr(REG_CTRL, 32'h1);
    wr(REG_CTRL, 32'h1);
    wait_done();
    rd(REG_STATUS);
    chk("sign_ovr", 32'h8, d & 32'hc);
    rd(REG_RESULT);
    chk("result", 32'd50, d);
    wr(REG_STATUS, 32'h2);
    wait_done();
    rd(REG_RESULT);
    chk("queued_result", 32'd50, d);
    $display("test overrange conversion finished");
    wr(REG_STATUS, 32'h2);
    sign <= 1'b1;
    dlen <= 16'd12;
    wr(REG_DEINTEGRATE_PHASE_MAX, 32'd200);
    wr(REG_CTRL, 32'h3);
    wait_done();
    wr(REG_STATUS, 32'h2);
    wait_done();
    wr(REG_CTRL, 32'h0);
    repeat (200) @(posedge clk_i);
    rd(REG_STATUS);
    chk("idle", 32'h10, d & 32'h31);
    $display("test continuous conversion finished");
    give_verdict();
  end
endmodule // tb_top
